// [design/esnt_defines.svh]
`ifndef ESNT_DEFINES_SVH
`define ESNT_DEFINES_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define ESNT_ADDR_TIME 8'h10
`define ESNT_ADDR_STATUS 8'h12
`define ESNT_ADDR_MASK 8'h14
`define ESNT_ADDR_CMD 8'h16
`define ESNT_ADDR_SEARCH 8'h1A

// ---------------------------------------------------------------
// status bit positions
// ---------------------------------------------------------------
`define ESNT_B_RECEIVE_ERROR_FLAG 15
`define ESNT_B_CORR 14
`define ESNT_B_UNLOCK 13
`define ESNT_B_WATCH 12
`define ESNT_B_FREE 11
`define ESNT_B_REMOTE 10
`define ESNT_B_OWN 9
`define ESNT_B_SRC 8
`define ESNT_B_RETRY 7
`define ESNT_B_RECOV 6
`define ESNT_B_HUB 5
`define ESNT_B_PTR 4
`define ESNT_B_CORE 3
`define ESNT_B_NOREPLY 2
`define ESNT_B_TRANSMIT_ERROR_FLAG 1
`define ESNT_B_TXFREE 0

// write-one-to-clear bits
`define ESNT_W1C_MASK 16'hCFF6
`define ESNT_TIME_RST 16'h0000
`define ESNT_MASK_RST 16'h0000
// unlock and transmitter-free read one out of hard reset
`define ESNT_STAT_RST 16'h2001

// ---------------------------------------------------------------
// command codes and pointer limits
// ---------------------------------------------------------------
`define ESNT_CMD_SEND 8'h03
`define ESNT_CMD_CANCEL 8'h01
`define ESNT_CMD_WATCH_CLR 8'h0A
`define ESNT_PTR_MIN_OK 8'h03

// ---------------------------------------------------------------
// hub watchdog timing
// ---------------------------------------------------------------
`define ESNT_CLK_MHZ 250
`define ESNT_HUB_TO_SLOW_US 3270
`define ESNT_HUB_TO_FAST_US 1640
`define ESNT_HUB_CYC_SLOW (`ESNT_HUB_TO_SLOW_US * `ESNT_CLK_MHZ)
`define ESNT_HUB_CYC_FAST (`ESNT_HUB_TO_FAST_US * `ESNT_CLK_MHZ)

`endif

// [design/esnt_pkg.sv]
package esnt_pkg;
    typedef enum logic [1:0] {
        ESNT_TX_IDLE = 2'b00,
        ESNT_TX_PEND = 2'b01
    } esnt_tx_t;
endpackage

// [design/esnt_hub_watch.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// hub transmit watchdog
// ---------------------------------------------------------------
module esnt_hub_watch #(
    parameter int CNT_W = 20,
    parameter int LIMIT_SLOW = 817500,
    parameter int LIMIT_FAST = 410000
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic hub_tx_active_i,
    input wire logic fast_rate_i,
    output logic timeout_o
);
    // refuse limits the counter cannot reach
    if (CNT_W < 2 || CNT_W > 30 || LIMIT_SLOW < 1 || LIMIT_FAST < 1
        || LIMIT_SLOW >= (1 << CNT_W) || LIMIT_FAST >= (1 << CNT_W))
    begin
        $error("esnt_hub_watch: limits do not fit the counter");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] limit;
    logic hit;

    // pulse once when the count reaches one below the limit, then restart
    always_comb
    begin
        limit = fast_rate_i ? CNT_W'(LIMIT_FAST) : CNT_W'(LIMIT_SLOW);
        hit = hub_tx_active_i && (cnt_r >= limit - CNT_W'(1));
        if (!hub_tx_active_i || hit)
            cnt_nxt = '0;
        else
            cnt_nxt = cnt_r + CNT_W'(1);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign timeout_o = hit;
endmodule
`default_nettype wire

// [design/esnt_event_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "esnt_defines.svh"
module esnt_event_unit
    import esnt_pkg::*;
#(
    parameter int HUB_CYC_SLOW = `ESNT_HUB_CYC_SLOW,
    parameter int HUB_CYC_FAST = `ESNT_HUB_CYC_FAST,
    parameter int PAGE_LIMIT = 255
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic soft_reset_i,
    // host bus
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic bus16_i,
    output logic [15:0] rdata_o,
    // time base
    input wire logic time_tick_i,
    input wire logic time_load_i,
    input wire logic [15:0] time_load_val_i,
    input wire logic time_master_i,
    input wire logic master_id_valid_i,
    input wire logic time_locked_i,
    // receive events
    input wire logic rx_error_i,
    input wire logic [2:0] rx_error_code_i,
    input wire logic [4:0] rx_sender_id_i,
    input wire logic rx_is_packet_i,
    input wire logic line_corr_i,
    input wire logic [3:0] corr_detail_i,
    input wire logic watch_expired_i,
    input wire logic free_page_done_i,
    input wire logic remote_page_done_i,
    input wire logic rx_ok_i,
    input wire logic rx_to_me_i,
    input wire logic [4:0] rx_source_id_i,
    // transmit events
    input wire logic pass_retry_i,
    input wire logic response_recovery_i,
    input wire logic hub_tx_active_i,
    input wire logic hub_on_i,
    input wire logic fast_rate_i,
    input wire logic tx_packet_i,
    input wire logic [7:0] tx_pointer_i,
    input wire logic core_irq_i,
    input wire logic enquiry_no_reply_i,
    input wire logic tx_fail_i,
    input wire logic tx_done_i,
    output logic send_req_o,
    output logic hub_reset_o,
    output logic line_reset_o,
    output logic [15:0] error_detail_o,
    output logic irq_o
);
    // the pointer compare is eight bits wide
    if (PAGE_LIMIT < 3 || PAGE_LIMIT > 255)
    begin
        $error("esnt_event_unit: PAGE_LIMIT out of range");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [15:0] time_r, time_nxt;
    logic [7:0] time_hi_r, time_hi_nxt;
    logic [15:0] stat_r, stat_nxt;
    logic [15:0] mask_r, mask_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [4:0] search_r, search_nxt;
    logic [15:0] detail_r, detail_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic unlock_r, unlock_nxt;
    esnt_tx_t tx_r, tx_nxt;
    logic hub_to;
    logic wr_stat, wr_cmd;
    logic [15:0] w1c, set_v;

    esnt_hub_watch #(
        .CNT_W(20),
        .LIMIT_SLOW(HUB_CYC_SLOW),
        .LIMIT_FAST(HUB_CYC_FAST)
    ) u_hub (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .hub_tx_active_i(hub_tx_active_i),
        .fast_rate_i(fast_rate_i),
        .timeout_o(hub_to)
    );

    // ---------------------------------------------------------------
    // time counter and byte latch
    // ---------------------------------------------------------------
    // the latch keeps 8-bit reads coherent across the carry between bytes
    always_comb
    begin
        time_nxt = time_r;
        time_hi_nxt = time_hi_r;
        if (soft_reset_i)
            time_nxt = `ESNT_TIME_RST;
        else if (time_load_i)
            time_nxt = time_load_val_i;
        else if (time_tick_i)
            time_nxt = time_r + 16'h0001;
        if (rd_i && !bus16_i && addr_i == `ESNT_ADDR_TIME)
            time_hi_nxt = time_r[15:8];
    end

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------
    always_comb
    begin
        wr_stat = wr_i && addr_i == `ESNT_ADDR_STATUS;
        wr_cmd = wr_i && addr_i == `ESNT_ADDR_CMD;
        w1c = wr_stat ? (wdata_i & `ESNT_W1C_MASK) : 16'h0000;
        // receive side in upper byte, transmit in lower
        set_v = 16'h0000;
        set_v[`ESNT_B_RECEIVE_ERROR_FLAG] = rx_error_i && rx_is_packet_i;
        set_v[`ESNT_B_CORR] = line_corr_i;
        set_v[`ESNT_B_WATCH] = watch_expired_i;
        set_v[`ESNT_B_FREE] = free_page_done_i;
        set_v[`ESNT_B_REMOTE] = remote_page_done_i;
        set_v[`ESNT_B_OWN] = rx_ok_i && rx_to_me_i;
        set_v[`ESNT_B_SRC] = rx_ok_i && rx_source_id_i == search_r;
        set_v[`ESNT_B_RETRY] = pass_retry_i;
        set_v[`ESNT_B_RECOV] = response_recovery_i;
        set_v[`ESNT_B_HUB] = hub_to;
        set_v[`ESNT_B_PTR] = tx_packet_i && (tx_pointer_i < `ESNT_PTR_MIN_OK
            || tx_pointer_i > 8'(PAGE_LIMIT));
        set_v[`ESNT_B_NOREPLY] = enquiry_no_reply_i;
        set_v[`ESNT_B_TRANSMIT_ERROR_FLAG] = tx_fail_i || enquiry_no_reply_i;
        stat_nxt = stat_r & ~w1c;
        if (wr_cmd && wdata_i[7:0] == `ESNT_CMD_WATCH_CLR)
            stat_nxt = stat_nxt & ~`ESNT_W1C_MASK & ~(16'h0001 << `ESNT_B_WATCH);
        if (wr_cmd && wdata_i[7:0] == `ESNT_CMD_SEND)
            stat_nxt = stat_nxt & ~16'h0006;
        stat_nxt = stat_nxt | set_v; // set wins over clear
        if (soft_reset_i)
            stat_nxt = 16'h0000;
        // mirrored bits come straight from live state
        stat_nxt[`ESNT_B_UNLOCK] = unlock_nxt;
        stat_nxt[`ESNT_B_CORE] = core_irq_i;
        stat_nxt[`ESNT_B_TXFREE] = (tx_nxt == ESNT_TX_IDLE);
    end

    // unlock flag: master always locked, others wait for evaluated id
    always_comb
    begin
        if (time_master_i)
            unlock_nxt = 1'b0;
        else if (soft_reset_i)
            unlock_nxt = 1'b1;
        else if (master_id_valid_i && time_locked_i)
            unlock_nxt = 1'b0;
        else if (!time_locked_i)
            unlock_nxt = 1'b1;
        else
            unlock_nxt = unlock_r;
    end

    // transmit pending from send command to done, fail, no reply, cancel or soft reset
    always_comb
    begin
        tx_nxt = tx_r;
        unique case (tx_r)
            ESNT_TX_IDLE:
                if (wr_cmd && wdata_i[7:0] == `ESNT_CMD_SEND)
                    tx_nxt = ESNT_TX_PEND;
            ESNT_TX_PEND:
                if (tx_done_i || tx_fail_i || enquiry_no_reply_i
                    || (wr_cmd && wdata_i[7:0] == `ESNT_CMD_CANCEL))
                    tx_nxt = ESNT_TX_IDLE;
        endcase
        if (soft_reset_i)
            tx_nxt = ESNT_TX_IDLE;
    end

    // ---------------------------------------------------------------
    // mask, command, search, detail and read mux
    // ---------------------------------------------------------------
    always_comb
    begin
        mask_nxt = mask_r;
        cmd_nxt = cmd_r;
        search_nxt = search_r;
        detail_nxt = detail_r;
        if (wr_i && addr_i == `ESNT_ADDR_MASK)
            mask_nxt = wdata_i;
        if (wr_cmd)
            cmd_nxt = wdata_i[7:0];
        if (wr_i && addr_i == `ESNT_ADDR_SEARCH)
            search_nxt = wdata_i[4:0];
        if (set_v[`ESNT_B_RECEIVE_ERROR_FLAG])
            detail_nxt = {detail_r[15:8], rx_error_code_i, rx_sender_id_i};
        if (line_corr_i)
            detail_nxt[11:8] = corr_detail_i;
        rdata_nxt = rdata_r;
        if (rd_i)
        begin
            unique case (addr_i)
                `ESNT_ADDR_TIME: rdata_nxt = time_r;
                `ESNT_ADDR_TIME + 8'h01: rdata_nxt = {8'h00, time_hi_r};
                `ESNT_ADDR_STATUS: rdata_nxt = stat_r;
                `ESNT_ADDR_MASK: rdata_nxt = mask_r;
                `ESNT_ADDR_CMD: rdata_nxt = {8'h00, cmd_r};
                `ESNT_ADDR_SEARCH: rdata_nxt = {11'h000, search_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            time_r <= `ESNT_TIME_RST;
            time_hi_r <= 8'h00;
            stat_r <= `ESNT_STAT_RST;
            mask_r <= `ESNT_MASK_RST;
            cmd_r <= 8'h00;
            search_r <= 5'h00;
            detail_r <= 16'h0000;
            rdata_r <= 16'h0000;
            unlock_r <= 1'b1;
            tx_r <= ESNT_TX_IDLE;
        end
        else
        begin
            time_r <= time_nxt;
            time_hi_r <= time_hi_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            cmd_r <= cmd_nxt;
            search_r <= search_nxt;
            detail_r <= detail_nxt;
            rdata_r <= rdata_nxt;
            unlock_r <= unlock_nxt;
            tx_r <= tx_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata_o = rdata_r;
    assign error_detail_o = detail_r;
    assign send_req_o = (tx_r == ESNT_TX_PEND);
    assign hub_reset_o = hub_to;
    assign line_reset_o = hub_to && hub_on_i;
    assign irq_o = |(stat_r & mask_r);
endmodule
`default_nettype wire

// [verification/esnt_event_unit_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module esnt_event_unit_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic soft_reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic bus16_i,
    input wire logic [15:0] rdata_o,
    input wire logic time_tick_i,
    input wire logic time_load_i,
    input wire logic [15:0] time_load_val_i,
    input wire logic rx_error_i,
    input wire logic [2:0] rx_error_code_i,
    input wire logic [4:0] rx_sender_id_i,
    input wire logic rx_is_packet_i,
    input wire logic line_corr_i,
    input wire logic [3:0] corr_detail_i,
    input wire logic hub_on_i,
    input wire logic tx_fail_i,
    input wire logic tx_done_i,
    input wire logic enquiry_no_reply_i,
    input wire logic send_req_o,
    input wire logic hub_reset_o,
    input wire logic line_reset_o,
    input wire logic [15:0] error_detail_o,
    input wire logic irq_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // bus steps shared by the checks
    sequence s_rd(a);
        rd_i && addr_i == a && bus16_i;
    endsequence
    sequence s_quiet;
        !time_tick_i && !time_load_i && !soft_reset_i;
    endsequence
    // a set in the same cycle would win over the send command
    sequence s_send;
        wr_i && addr_i == 8'h16 && wdata_i[7:0] == 8'h03 && !soft_reset_i && !tx_fail_i
            && !tx_done_i && !enquiry_no_reply_i;
    endsequence
    // nothing may end or undo the send in the gap before the read
    sequence s_still;
        !wr_i && !soft_reset_i && !tx_fail_i && !tx_done_i && !enquiry_no_reply_i;
    endsequence
    AST_TIME_STEADY: assert property ((s_rd(8'h10) and s_quiet) ##1 s_rd(8'h10) |=> rdata_o == $past(rdata_o))
        else $error("time moved without tick");
    AST_TIME_LOAD: assert property ((time_load_i && !soft_reset_i) ##1 s_quiet ##1 s_rd(8'h10)
        |=> rdata_o == $past(time_load_val_i, 3))
        else $error("loaded time not read back");
    AST_SEND_PEND: assert property (s_send |=> send_req_o)
        else $error("send not pending");
    AST_SEND_STATUS: assert property (s_send ##1 s_still ##1 s_rd(8'h12) |=> rdata_o[2:0] == 3'b000)
        else $error("transmit bits wrong after send");
    AST_ERR_INFO: assert property (rx_error_i && rx_is_packet_i && !soft_reset_i
        |=> error_detail_o[7:5] == $past(rx_error_code_i) && error_detail_o[4:0] == $past(rx_sender_id_i))
        else $error("receive error detail wrong");
    AST_CORR_INFO: assert property (line_corr_i && !soft_reset_i |=> error_detail_o[11:8] == $past(corr_detail_i))
        else $error("correction detail wrong");
    AST_LINE_RESET: assert property (line_reset_o == (hub_reset_o && hub_on_i))
        else $error("line reset wrong");
    AST_MASK_OFF: assert property (wr_i && addr_i == 8'h14 && wdata_i == 16'h0000 |=> !irq_o)
        else $error("irq with zero mask");
endmodule
bind esnt_event_unit esnt_event_unit_asserts esnt_event_unit_asserts_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .bus16_i(bus16_i), .rdata_o(rdata_o), .time_tick_i(time_tick_i),
    .time_load_i(time_load_i), .time_load_val_i(time_load_val_i), .rx_error_i(rx_error_i),
    .rx_error_code_i(rx_error_code_i), .rx_sender_id_i(rx_sender_id_i), .rx_is_packet_i(rx_is_packet_i),
    .line_corr_i(line_corr_i), .corr_detail_i(corr_detail_i), .hub_on_i(hub_on_i), .tx_fail_i(tx_fail_i),
    .tx_done_i(tx_done_i), .enquiry_no_reply_i(enquiry_no_reply_i), .send_req_o(send_req_o),
    .hub_reset_o(hub_reset_o), .line_reset_o(line_reset_o), .error_detail_o(error_detail_o), .irq_o(irq_o));
`default_nettype wire

// [verification/esnt_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// host bus master
// ----
module esnt_host_model (
    input wire logic ref_clk_i,
    input wire logic [15:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        {addr_o, wdata_o, wr_o, rd_o} = '0;
    end
    // n strobes in a row; q holds read data after the last
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, input int n,
        output logic [15:0] q);
        @(negedge ref_clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        repeat (n) @(negedge ref_clk_i);
        q = rdata_i;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a; // released lines do not keep old value
        wdata_o = ~d;
    endtask
    task automatic send();
        logic [15:0] q;
        acc(1'b1, 8'h16, 16'h0003, 1, q);
    endtask
    task automatic clr();
        logic [15:0] q;
        acc(1'b1, 8'h16, 16'h000A, 1, q);
    endtask
endmodule
`default_nettype wire

// [verification/esnt_event_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module esnt_event_unit_tb;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] ev = '0;
    logic [7:0] dv = '0;
    logic nopkt = 1'b0;
    logic master, id_ok, locked, hub_act, hub_on, fast, core, bus16;
    logic [15:0] q;
    int k, failures = 0, cmp_count = 0;
    wire logic [7:0] addr;
    wire logic [15:0] wdata, rdata;
    wire logic wr, rd, send_req, hub_rst, line_rst, irq;
    // rows: pulses, data byte, status bits expected
    logic [39:0] rows [16] = '{40'h0001A58000, 40'h00020C4000, 40'h0004001000, 40'h0008000800,
        40'h0010000400, 40'h0020000200, 40'h0800000100, 40'h0040000080, 40'h0080000040, 40'h0100000010,
        40'h0100020010, 40'h0100030000, 40'h0100C80000, 40'h0100C90010, 40'h0200000006, 40'h0400000002};
    always #2 ref_clk_i = ~ref_clk_i;
    esnt_event_unit #(.HUB_CYC_SLOW(20), .HUB_CYC_FAST(10), .PAGE_LIMIT(200)) esnt_event_unit_i (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .soft_reset_i(ev[15]), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .bus16_i(bus16), .rdata_o(rdata), .time_tick_i(ev[12]), .time_load_i(ev[13]),
        .time_load_val_i({dv, dv}), .time_master_i(master), .master_id_valid_i(id_ok), .time_locked_i(locked),
        .rx_error_i(ev[0]), .rx_error_code_i(dv[7:5]), .rx_sender_id_i(dv[4:0]), .rx_is_packet_i(!nopkt),
        .line_corr_i(ev[1]), .corr_detail_i(dv[3:0]), .watch_expired_i(ev[2]), .free_page_done_i(ev[3]),
        .remote_page_done_i(ev[4]), .rx_ok_i(ev[5] | ev[11]), .rx_to_me_i(ev[5]), .rx_source_id_i({5{!ev[11]}}),
        .pass_retry_i(ev[6]), .response_recovery_i(ev[7]), .hub_tx_active_i(hub_act), .hub_on_i(hub_on),
        .fast_rate_i(fast), .tx_packet_i(ev[8]), .tx_pointer_i(dv), .core_irq_i(core),
        .enquiry_no_reply_i(ev[9]), .tx_fail_i(ev[10]), .tx_done_i(ev[14]), .send_req_o(send_req),
        .hub_reset_o(hub_rst), .line_reset_o(line_rst), .error_detail_o(), .irq_o(irq));
    esnt_host_model esnt_host_model_i (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    // ----
    // tasks
    // ----
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdx(input logic [7:0] a, input int n, input logic [15:0] e);
        logic [15:0] r;
        esnt_host_model_i.acc(1'b0, a, 16'h0000, n, r);
        chk(r, e);
    endtask
    task automatic wrx(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] r;
        esnt_host_model_i.acc(1'b1, a, d, 1, r);
    endtask
    task automatic pulse(input logic [15:0] e, input logic [7:0] d);
        @(negedge ref_clk_i);
        ev = e;
        dv = d;
        @(negedge ref_clk_i);
        ev = '0;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        {master, id_ok, locked, hub_act, hub_on, fast, core, bus16} = 8'h01;
        repeat (3) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        rdx(8'h12, 1, 16'h2001);
        rdx(8'h14, 1, 16'h0000);
        rdx(8'h10, 1, 16'h0000);
        rdx(8'h1C, 1, 16'h0000); // unmapped place reads zero
        {id_ok, locked} = 2'b11;
        rdx(8'h12, 1, 16'h0001);
        {master, id_ok} = 2'b10;
        rdx(8'h12, 1, 16'h0001);
        // each event alone: set, write-one clear, command clear
        foreach (rows[i])
        begin
            wrx(8'h14, rows[i][15:0]);
            pulse(rows[i][39:24], rows[i][23:16]);
            rdx(8'h12, 1, rows[i][15:0] | 16'h0001);
            chk({15'h0, irq}, {15'h0, |rows[i][15:0]});
            wrx(8'h12, 16'hFFFF);
            rdx(8'h12, 1, (rows[i][15:0] & 16'h3009) | 16'h0001);
            esnt_host_model_i.clr();
            rdx(8'h12, 1, 16'h0001);
        end
        repeat (5) pulse(16'h1000, 8'h00);
        rdx(8'h10, 2, 16'h0005);
        wrx(8'h10, 16'h0000);
        pulse(16'h2000, 8'hFF);
        rdx(8'h10, 1, 16'hFFFF);
        bus16 = 1'b0;
        esnt_host_model_i.acc(1'b0, 8'h10, 16'h0000, 1, q);
        chk({8'h00, q[7:0]}, 16'h00FF);
        pulse(16'h1000, 8'h00);
        esnt_host_model_i.acc(1'b0, 8'h11, 16'h0000, 1, q);
        chk({8'h00, q[7:0]}, 16'h00FF);
        bus16 = 1'b1;
        pulse(16'h0200, 8'h00);
        rdx(8'h12, 1, 16'h0007);
        esnt_host_model_i.send();
        chk({15'h0, send_req}, 16'h0001);
        rdx(8'h12, 1, 16'h0000);
        pulse(16'h4000, 8'h00);
        rdx(8'h12, 1, 16'h0001);
        wrx(8'h14, 16'hFFFF);
        rdx(8'h14, 1, 16'hFFFF);
        chk({15'h0, irq}, 16'h0001);
        core = 1'b1;
        rdx(8'h12, 1, 16'h0009);
        core = 1'b0;
        // an error on a non-packet frame must not flag; then a send taken back
        nopkt = 1'b1;
        pulse(16'h0001, 8'h00);
        nopkt = 1'b0;
        rdx(8'h12, 1, 16'h0001);
        esnt_host_model_i.send();
        wrx(8'h16, 16'h0001);
        chk({15'h0, send_req}, 16'h0000);
        rdx(8'h12, 1, 16'h0001);
        // hub watchdog at both rates, hub on only for fast
        for (int r = 0; r < 2; r++)
        begin
            {fast, hub_on, hub_act} = {r[0], r[0], 1'b1};
            k = 0;
            while (!hub_rst && k < 100)
            begin
                @(negedge ref_clk_i);
                k++;
            end
            if (k == 100)
            begin
                failures++;
                conclude();
            end
            // pulse shows one cycle before the edge that makes the limit count
            chk({15'h0, k >= (r ? 9 : 19) && k <= (r ? 11 : 21)}, 16'h0001);
            chk({15'h0, line_rst}, {15'h0, r[0]});
            // keep the line active through the edge that takes the flag
            @(negedge ref_clk_i);
            hub_act = 1'b0;
            rdx(8'h12, 1, 16'h0021);
            wrx(8'h12, 16'h0020);
            rdx(8'h12, 1, 16'h0001);
        end
        pulse(16'h0040, 8'h00);
        pulse(16'h8000, 8'h00);
        rdx(8'h12, 1, 16'h0001);
        rdx(8'h10, 1, 16'h0000);
        master = 1'b0;
        pulse(16'h8000, 8'h00);
        rdx(8'h12, 1, 16'h2001);
        conclude();
    end
endmodule
`default_nettype wire
